/* File: include/e1r_pkg.sv */
// Constants, field layouts and carriers of the E1 receive side pin block.
// Assumes a 200 MHz system clock and an Avalon-MM master in the same domain.
//
// What this block does
// R1 - Link demand output high for 1 to 5 bit times from slot 0 bit 3 of odd frames, length set by control bits 6:4.
// R2 - Receive clock pin carries the recovered 2.048 MHz line clock.
// R3 - 256 KHz channel clock is high only during each channel's LSB.
// R4 - Serial data changes on rising recovered clock, or backplane clock with store.
// R5 - Output sync pulses one clock: frame when select bit 0, multiframe when 1.
// R6 - With store and direction bit set, sync pin is an input taking frame pulses.
// R7 - Loss output, select 0: high while synchronizer searches for alignment.
// R8 - Loss output, select 1: high after 5 us without transmit clock transition.
// R9 - Backplane clock used only with elastic store; otherwise held low outside.
// R10 - Backplane clock high 100 us or more tri-states every output pin.
// R11 - Channel block output follows a programmed bit for each of 32 channels.
// R12 - On carrier loss the alternate clock replaces the recovered clock.
// R13 - Bus type strap picks strobe scheme of the host port control pins.
// R14 - First open-drain low interrupt asserts while an unmasked status one bit stays latched.
// R15 - Second open-drain low interrupt asserts while an unmasked status two bit stays latched.
// R16 - Frame has 32 eight-bit slots, slot 0 first, MSB first.
// R17 - Channel clock, block and sync are timed with the serial data clock.
// R18 - Interrupt lines release once no reported condition remains.
package e1r_pkg;

  // ----------------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_BLOCK   = 4'h1;
  localparam logic [3:0] REG_STAT1   = 4'h2;
  localparam logic [3:0] REG_STAT2   = 4'h3;
  localparam logic [3:0] REG_MASK1   = 4'h4;
  localparam logic [3:0] REG_MASK2   = 4'h5;
  localparam logic [3:0] REG_STATE   = 4'h6;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CTRL_SYNC_SEL_POS  = 0;
  localparam int CTRL_SYNC_DIR_POS  = 1;
  localparam int CTRL_ES_EN_POS     = 2;
  localparam int CTRL_LOSS_SEL_POS  = 3;
  localparam int CTRL_LINK_RATE_POS = 4;
  localparam int S1_SEARCH_POS      = 0;
  localparam int S1_CARRIER_POS     = 1;
  localparam int S1_TXCLK_POS       = 2;
  localparam int S2_FRAME_POS       = 0;
  localparam int S2_MFRAME_POS      = 1;
  localparam int S2_TRISTATE_POS    = 2;

  // ----------------------------------------------------------------------
  // Reset values and frame geometry.
  // ----------------------------------------------------------------------
  localparam logic [2:0]  LINK_RATE_RST = 3'h5;
  localparam logic [2:0]  LINK_RATE_MAX = 3'h5;
  localparam logic [31:0] BLOCK_RST     = 32'h00000000;
  localparam logic [2:0]  MASK_RST      = 3'h7;
  localparam logic [2:0]  LSB_BIT       = 3'h7;
  localparam logic [2:0]  FIRST_SA_BIT  = 3'h3;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int TXCLK_LOSS_NS   = 5000;
  localparam int TXCLK_LOSS_CYC  = (TXCLK_LOSS_NS * CLK_MHZ) / 1000;
  localparam int BP_HIGH_US      = 100;
  localparam int BP_HIGH_CYC     = BP_HIGH_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] link_rate;
    logic       loss_select_bit;
    logic       elastic_store_enable_bit;
    logic       rx_sync_direction_bit;
    logic       rx_sync_select_bit;
  } e1r_ctrl_s;

  typedef struct packed {
    logic [4:0] chan;
    logic [2:0] bit_idx;
    logic [3:0] frame;
  } e1r_pos_s;

endpackage : e1r_pkg

/* File: rtl/e1r_rx_pins.sv */
// E1 receive side pin logic with Avalon-MM register slave.
// All pin inputs are asynchronous and are sampled by clk_in through three flops and a stability filter flop.
module e1r_rx_pins #(
  parameter int BP_HIGH_CYCLES = e1r_pkg::BP_HIGH_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        rx_recovered_clock_in,
  input  wire logic        rx_line_data_in,
  input  wire logic        carrier_loss_in,
  input  wire logic        sync_search_in,
  input  wire logic        alternate_clock_in,
  input  wire logic        backplane_clock_in,
  input  wire logic        tx_primary_clock_in,
  input  wire logic        bus_type_strap_in,
  input  wire logic        rx_frame_sync_pin_in,
  output logic             rx_frame_sync_pin_out,
  output logic             rx_frame_sync_pin_oe_out,
  output logic             rx_clock_out,
  output logic             rx_serial_data_out,
  output logic             rx_channel_clock_out,
  output logic             rx_channel_block_out,
  output logic             rx_link_demand_clock_out,
  output logic             rx_link_data_out,
  output logic             sync_or_txclk_loss_out,
  output logic             pins_drive_en_out,
  output logic             bus_mode_strobe_out,
  output logic             alarm_irq_first_n_out,
  output logic             alarm_irq_first_n_oe_out,
  output logic             alarm_irq_second_n_out,
  output logic             alarm_irq_second_n_oe_out,
  output logic             irq_out
);
  import e1r_pkg::*;

  if (BP_HIGH_CYCLES < 2) begin : g_bp_check
    $error("BP_HIGH_CYCLES must be at least 2.");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, stab_ff, prev_ff;
  logic [NSYNC-1:0] nxt_stab;
  assign raw_in = {rx_frame_sync_pin_in, bus_type_strap_in, tx_primary_clock_in,
                   backplane_clock_in, alternate_clock_in, sync_search_in,
                   carrier_loss_in, rx_line_data_in, rx_recovered_clock_in};

  always_comb begin
    for (int i = 0; i < NSYNC; i++) begin
      nxt_stab[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : stab_ff[i];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      stab_ff <= '0;
      prev_ff <= '0;
    end else begin
      s1_ff   <= raw_in;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      stab_ff <= nxt_stab;
      prev_ff <= stab_ff;
    end
  end

  logic rclk_s, rdata_s, carrier_s, search_s, aclk_s, bpclk_s, tx_primary_clock_s, strap_s, sync_s;
  assign {sync_s, strap_s, tx_primary_clock_s, bpclk_s, aclk_s, search_s, carrier_s, rdata_s, rclk_s}
    = stab_ff;
  logic [NSYNC-1:0] rise;
  assign rise = stab_ff & ~prev_ff;

  // ----------------------------------------------------------------------
  // Registers and Avalon-MM slave.
  // ----------------------------------------------------------------------
  e1r_ctrl_s   ctrl_ff, nxt_ctrl;
  logic [31:0] block_ff, nxt_block;
  logic [2:0]  stat1_ff, nxt_stat1, stat2_ff, nxt_stat2;
  logic [2:0]  mask1_ff, nxt_mask1, mask2_ff, nxt_mask2;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0]  set1, set2;
  logic        wr_go;
  logic        strap_ff, nxt_strap;
  logic        tristate_ff;
  logic        loss_ff;

  assign wr_go = avs_write_in & ack_ff;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
  assign avs_readdata_out = rdata_ff;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_block = block_ff;
    nxt_mask1 = mask1_ff;
    nxt_mask2 = mask2_ff;
    nxt_stat1 = stat1_ff;
    nxt_stat2 = stat2_ff;
    nxt_rdata = rdata_ff;
    nxt_ack   = (avs_read_in | avs_write_in) & ~ack_ff;
    if (wr_go) begin
      case (avs_address_in)
        REG_CTRL: begin
          nxt_ctrl = e1r_ctrl_s'(avs_writedata_in[6:0]);
          if (avs_writedata_in[CTRL_LINK_RATE_POS +: 3] > LINK_RATE_MAX ||
              avs_writedata_in[CTRL_LINK_RATE_POS +: 3] == 3'h0) begin
            nxt_ctrl.link_rate = LINK_RATE_MAX;
          end
        end
        REG_BLOCK: nxt_block = avs_writedata_in;
        REG_STAT1: nxt_stat1 = stat1_ff & ~avs_writedata_in[2:0];
        REG_STAT2: nxt_stat2 = stat2_ff & ~avs_writedata_in[2:0];
        REG_MASK1: nxt_mask1 = avs_writedata_in[2:0];
        REG_MASK2: nxt_mask2 = avs_writedata_in[2:0];
        default: begin
        end
      endcase
    end
    nxt_stat1 = nxt_stat1 | set1;
    nxt_stat2 = nxt_stat2 | set2;
    if (avs_read_in & ~ack_ff) begin
      case (avs_address_in)
        REG_CTRL:  nxt_rdata = {25'h0000000, ctrl_ff};
        REG_BLOCK: nxt_rdata = block_ff;
        REG_STAT1: nxt_rdata = {29'h00000000, stat1_ff};
        REG_STAT2: nxt_rdata = {29'h00000000, stat2_ff};
        REG_MASK1: nxt_rdata = {29'h00000000, mask1_ff};
        REG_MASK2: nxt_rdata = {29'h00000000, mask2_ff};
        REG_STATE: nxt_rdata = {26'h0000000, carrier_s, search_s, tx_primary_clock_s, loss_ff,
                                tristate_ff, strap_ff};
        default:   nxt_rdata = 32'h00000000;
      endcase
    end
    nxt_strap = strap_s;                                             // [R13]
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_ff       <= e1r_ctrl_s'({LINK_RATE_RST, 4'h0});
      block_ff      <= BLOCK_RST;
      mask1_ff      <= MASK_RST;
      mask2_ff      <= MASK_RST;
      stat1_ff      <= 3'h0;
      stat2_ff      <= 3'h0;
      rdata_ff      <= 32'h00000000;
      ack_ff        <= 1'b0;
      strap_ff      <= 1'b0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      block_ff      <= nxt_block;
      mask1_ff      <= nxt_mask1;
      mask2_ff      <= nxt_mask2;
      stat1_ff      <= nxt_stat1;
      stat2_ff      <= nxt_stat2;
      rdata_ff      <= nxt_rdata;
      ack_ff        <= nxt_ack;
      strap_ff      <= nxt_strap;
    end
  end

  // ----------------------------------------------------------------------
  // Loss detectors and tri-state override.
  // ----------------------------------------------------------------------
  logic [10:0] tgap_ff, nxt_tgap;
  logic [31:0] bphi_ff, nxt_bphi;
  logic        txlost, nxt_tristate, nxt_loss, search_d_ff, carrier_d_ff, txlost_d_ff;
  assign txlost = (tgap_ff >= 11'(TXCLK_LOSS_CYC));

  always_comb begin
    nxt_tgap = (tx_primary_clock_s != prev_ff[6]) ? 11'h000 :                   // [R8]
               (txlost ? tgap_ff : tgap_ff + 11'h001);
    nxt_bphi = !bpclk_s ? 32'h00000000 :                            // [R10]
               ((bphi_ff >= 32'(BP_HIGH_CYCLES)) ? bphi_ff : bphi_ff + 32'h00000001);
    nxt_tristate = (bphi_ff >= 32'(BP_HIGH_CYCLES));                 // [R10]
    nxt_loss = ctrl_ff.loss_select_bit ? txlost : search_s;          // [R7] [R8]
    set1 = 3'h0;
    set1[S1_SEARCH_POS]  = search_s & ~search_d_ff;
    set1[S1_CARRIER_POS] = carrier_s & ~carrier_d_ff;
    set1[S1_TXCLK_POS]   = txlost & ~txlost_d_ff;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tgap_ff      <= 11'h000;
      bphi_ff      <= 32'h00000000;
      tristate_ff  <= 1'b0;
      loss_ff      <= 1'b0;
      search_d_ff  <= 1'b0;
      carrier_d_ff <= 1'b0;
      txlost_d_ff  <= 1'b0;
    end else begin
      tgap_ff      <= nxt_tgap;
      bphi_ff      <= nxt_bphi;
      tristate_ff  <= nxt_tristate;
      loss_ff      <= nxt_loss;
      search_d_ff  <= search_s;
      carrier_d_ff <= carrier_s;
      txlost_d_ff  <= txlost;
    end
  end

  // ----------------------------------------------------------------------
  // Frame timing, serial data and pin outputs.
  // ----------------------------------------------------------------------
  e1r_pos_s pos_ff, nxt_pos;
  logic     tick, sync_in_mode, ext_sync;
  logic     rclk_o_ff, nxt_rclk_o, ser_ff, nxt_ser, chclk_ff, nxt_chclk;
  logic     blk_ff, nxt_blk, sync_o_ff, nxt_sync_o, lclk_ff, nxt_lclk, ldat_ff, nxt_ldat;

  assign sync_in_mode = ctrl_ff.elastic_store_enable_bit & ctrl_ff.rx_sync_direction_bit; // [R6]
  assign tick = ctrl_ff.elastic_store_enable_bit ? rise[5] :         // [R4] [R9]
                (carrier_s ? rise[4] : rise[0]);                     // [R4] [R12]
  assign ext_sync = sync_in_mode & rise[8];                          // [R6]

  function automatic e1r_pos_s pos_step(input e1r_pos_s p);
    e1r_pos_s n;
    n = p;
    n.bit_idx = p.bit_idx + 3'h1;                                    // [R16]
    if (p.bit_idx == LSB_BIT) begin
      n.chan = p.chan + 5'h01;
      if (p.chan == 5'h1F) begin
        n.frame = p.frame + 4'h1;
      end
    end
    return n;
  endfunction : pos_step

  always_comb begin
    nxt_pos    = pos_ff;
    nxt_ser    = ser_ff;
    nxt_chclk  = chclk_ff;
    nxt_blk    = blk_ff;
    nxt_sync_o = sync_o_ff;
    nxt_lclk   = lclk_ff;
    nxt_ldat   = ldat_ff;
    nxt_rclk_o = carrier_s ? aclk_s : rclk_s;                        // [R2] [R12]
    if (ext_sync) begin
      nxt_pos = e1r_pos_s'(12'h000);                                 // [R6]
    end else if (tick) begin
      nxt_pos = pos_step(pos_ff);                                    // [R16]
    end
    if (tick) begin
      nxt_ser    = rdata_s;                                          // [R4]
      nxt_chclk  = (nxt_pos.bit_idx == LSB_BIT);                     // [R3] [R17]
      nxt_blk    = block_ff[nxt_pos.chan];                           // [R11] [R17]
      nxt_sync_o = (nxt_pos.chan == 5'h00) && (nxt_pos.bit_idx == 3'h0) &&
                   (!ctrl_ff.rx_sync_select_bit || nxt_pos.frame == 4'h0); // [R5] [R17]
      nxt_lclk   = nxt_pos.frame[0] && (nxt_pos.chan == 5'h00) &&
                   (nxt_pos.bit_idx >= FIRST_SA_BIT) &&
                   ((nxt_pos.bit_idx - FIRST_SA_BIT) < ctrl_ff.link_rate); // [R1]
      nxt_ldat   = rdata_s;                                          // [R1]
    end
    set2 = 3'h0;
    set2[S2_FRAME_POS]    = tick & (nxt_pos.chan == 5'h00) & (nxt_pos.bit_idx == 3'h0);
    set2[S2_MFRAME_POS]   = set2[S2_FRAME_POS] & (nxt_pos.frame == 4'h0);
    set2[S2_TRISTATE_POS] = nxt_tristate & ~tristate_ff;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pos_ff    <= e1r_pos_s'(12'h000);
      rclk_o_ff <= 1'b0;
      ser_ff    <= 1'b0;
      chclk_ff  <= 1'b0;
      blk_ff    <= 1'b0;
      sync_o_ff <= 1'b0;
      lclk_ff   <= 1'b0;
      ldat_ff   <= 1'b0;
    end else begin
      pos_ff    <= nxt_pos;
      rclk_o_ff <= nxt_rclk_o;
      ser_ff    <= nxt_ser;
      chclk_ff  <= nxt_chclk;
      blk_ff    <= nxt_blk;
      sync_o_ff <= nxt_sync_o;
      lclk_ff   <= nxt_lclk;
      ldat_ff   <= nxt_ldat;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers and interrupts.
  // ----------------------------------------------------------------------
  logic alarm_irq_first_n, alarm_irq_second_n;
  assign alarm_irq_first_n = |(stat1_ff & mask1_ff);                              // [R14] [R18]
  assign alarm_irq_second_n = |(stat2_ff & mask2_ff);                              // [R15] [R18]
  assign pins_drive_en_out         = ~tristate_ff;                   // [R10]
  assign rx_clock_out              = rclk_o_ff;
  assign rx_serial_data_out        = ser_ff;
  assign rx_channel_clock_out      = chclk_ff;
  assign rx_channel_block_out      = blk_ff;
  assign rx_link_demand_clock_out  = lclk_ff;
  assign rx_link_data_out          = ldat_ff;
  assign sync_or_txclk_loss_out    = loss_ff;
  assign bus_mode_strobe_out       = strap_ff;                       // [R13]
  assign rx_frame_sync_pin_out     = sync_o_ff;
  assign rx_frame_sync_pin_oe_out  = ~sync_in_mode & ~tristate_ff;   // [R6] [R10]
  assign alarm_irq_first_n_out     = 1'b0;
  assign alarm_irq_first_n_oe_out  = alarm_irq_first_n & ~tristate_ff;            // [R14]
  assign alarm_irq_second_n_out    = 1'b0;
  assign alarm_irq_second_n_oe_out = alarm_irq_second_n & ~tristate_ff;            // [R15]
  assign irq_out                   = alarm_irq_first_n | alarm_irq_second_n;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  property p_chclk;
    @(posedge clk_in) disable iff (!rstn_in)
      tick && !ext_sync |=> (chclk_ff == (pos_ff.bit_idx == LSB_BIT));
  endproperty
  a_chclk: assert property (p_chclk) else $error("Channel clock not on LSB."); // [R3]

  property p_block;
    @(posedge clk_in) disable iff (!rstn_in)
      tick |=> (blk_ff == $past(block_ff[nxt_pos.chan]));
  endproperty
  a_block: assert property (p_block) else $error("Channel block mismatch."); // [R11]

  property p_ser;
    @(posedge clk_in) disable iff (!rstn_in)
      !tick |=> $stable(ser_ff);
  endproperty
  a_ser: assert property (p_ser) else $error("Serial data changed off edge."); // [R4]

  property p_sync_one;
    @(posedge clk_in) disable iff (!rstn_in)
      $rose(sync_o_ff) |-> !ctrl_ff.rx_sync_select_bit || pos_ff.frame == 4'h0;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("Sync on wrong frame."); // [R5]

  property p_loss7;
    @(posedge clk_in) disable iff (!rstn_in)
      !ctrl_ff.loss_select_bit ##1 !$past(ctrl_ff.loss_select_bit) |->
        loss_ff == $past(search_s);
  endproperty
  a_loss7: assert property (p_loss7) else $error("Loss output not search."); // [R7]

  property p_txloss;
    @(posedge clk_in) disable iff (!rstn_in)
      ctrl_ff.loss_select_bit && tgap_ff == 11'(TXCLK_LOSS_CYC) && $stable(ctrl_ff)
        |=> loss_ff;
  endproperty
  a_txloss: assert property (p_txloss) else $error("Tx clock loss not flagged."); // [R8]

  property p_tri;
    @(posedge clk_in) disable iff (!rstn_in)
      bphi_ff >= 32'(BP_HIGH_CYCLES) |=> !pins_drive_en_out && !rx_frame_sync_pin_oe_out;
  endproperty
  a_tri: assert property (p_tri) else $error("Outputs not tri-stated."); // [R10]

  property p_syncin;
    @(posedge clk_in) disable iff (!rstn_in)
      sync_in_mode |-> !rx_frame_sync_pin_oe_out;
  endproperty
  a_syncin: assert property (p_syncin) else $error("Sync pin driven as input."); // [R6]

  property p_alarm_irq_first_n;
    @(posedge clk_in) disable iff (!rstn_in)
      (stat1_ff & mask1_ff) == 3'h0 && !tristate_ff |-> !alarm_irq_first_n_oe_out;
  endproperty
  a_alarm_irq_first_n: assert property (p_alarm_irq_first_n) else $error("First interrupt held."); // [R18]

  property p_alarm_irq_second_n;
    @(posedge clk_in) disable iff (!rstn_in)
      $rose(stat2_ff[S2_FRAME_POS]) && mask2_ff[S2_FRAME_POS] && !tristate_ff
        |-> alarm_irq_second_n_oe_out;
  endproperty
  a_alarm_irq_second_n: assert property (p_alarm_irq_second_n) else $error("Second interrupt missing."); // [R15]

  property p_rclk;
    @(posedge clk_in) disable iff (!rstn_in)
      carrier_s ##1 carrier_s |-> rclk_o_ff == $past(aclk_s);
  endproperty
  a_rclk: assert property (p_rclk) else $error("Alternate clock not routed."); // [R12]

  c_mframe: cover property (@(posedge clk_in) disable iff (!rstn_in)
    sync_o_ff && ctrl_ff.rx_sync_select_bit);
  c_link: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(lclk_ff));
  c_tri: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(tristate_ff));

endmodule : e1r_rx_pins

/* File: tb/e1r_far_end.sv */
// Far side model: line recovery front end, transmit clock source and backplane.
// Assumes the bench owns the system clock; the link clocks here are unrelated to it.
module e1r_far_end (
  input  wire logic tx_run_in,
  input  wire logic bp_hold_in,
  output logic      rec_clk_out,
  output logic      line_data_out,
  output logic      tx_clk_out,
  output logic      bp_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat;
  // ----------------------------------------------------------------
  // Recovered clock at 80 ns and a changing line pattern.
  // ----------------------------------------------------------------
  initial begin
    rec_clk_out = 1'b0;
    tx_clk_out = 1'b0;
    pat = 8'hA5;
    forever #40 rec_clk_out = ~rec_clk_out;
  end
  // Line data moves on the falling edge so it is steady at the rising edge.
  always @(negedge rec_clk_out) pat <= {pat[6:0], pat[7] ^ pat[5]};
  assign line_data_out = pat[7];
  // Transmit clock stands still while stopped.
  always #244 if (tx_run_in) tx_clk_out = ~tx_clk_out;
  // Backplane clock is held low unless a test holds it high.
  assign bp_clk_out = bp_hold_in;
endmodule : e1r_far_end

/* File: tb/test_e1r_rx_pins.sv */
// Self-checking bench of the receive side pin block over its Avalon-MM port.
// Assumes the far side model drives the link clocks and line data.
module test_e1r_rx_pins;
  timeunit 1ns;
  timeprecision 1ps;
  import e1r_pkg::*;
  logic        clk_in, rstn_in, rd, wr, tx_run, bp_hold, search, cl;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        wreq, rclk, ldat, tx_primary_clock, bclk, s_out, s_oe, ch_clk, loss, drv, i1, i2, irq;
  logic        bus_type_strap, bm, rco, ser, ldo, blk, lco, a1, a2;
  int          fails, compares, c, b, l, r, s, e;
  e1r_far_end u_e1r_far_end (.tx_run_in(tx_run), .bp_hold_in(bp_hold), .rec_clk_out(rclk),
    .line_data_out(ldat), .tx_clk_out(tx_primary_clock), .bp_clk_out(bclk));
  e1r_rx_pins #(.BP_HIGH_CYCLES(50)) u_e1r_rx_pins (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .rx_recovered_clock_in(rclk),
    .rx_line_data_in(ldat), .carrier_loss_in(cl), .sync_search_in(search),
    .alternate_clock_in(1'b0), .backplane_clock_in(bclk), .tx_primary_clock_in(tx_primary_clock),
    .bus_type_strap_in(bus_type_strap), .rx_frame_sync_pin_in(s_oe ? s_out : 1'b1),
    .rx_frame_sync_pin_out(s_out), .rx_frame_sync_pin_oe_out(s_oe), .rx_clock_out(rco),
    .rx_serial_data_out(ser), .rx_channel_clock_out(ch_clk), .rx_channel_block_out(blk),
    .rx_link_demand_clock_out(lco), .rx_link_data_out(ldo), .sync_or_txclk_loss_out(loss),
    .pins_drive_en_out(drv), .bus_mode_strobe_out(bm), .alarm_irq_first_n_out(a1),
    .alarm_irq_first_n_oe_out(i1), .alarm_irq_second_n_out(a2), .alarm_irq_second_n_oe_out(i2),
    .irq_out(irq));
  // ----------------------------------------------------------------
  // Checking and closing tasks.
  // ----------------------------------------------------------------
  task automatic results;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_up;
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask : give_up
  // ----------------------------------------------------------------
  // Bus cycles: hold the request until waitrequest is sampled low.
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= ~w;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) give_up();
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  // Counts output pulses over the two frames that follow a frame sync pulse.
  task automatic count_chan;
    int n, k;
    logic ps, pc, pl, pr, pd;
    k = 0;
    {c, b, l, r, s, e} = '0;
    {ps, pc, pl, pr, pd} = 5'h1F;
    for (n = 0; n < 20000 && k < 3; n++) begin
      @(negedge clk_in);
      if (k > 0) begin
        if (ch_clk && !pc) c++;
        if (ch_clk && !pc && blk) b++;
        if (lco && !pl) l++;
        if (rco && !pr) r++;
        if (ser && !pd) s++;
        if (ser !== ldo) e++;
      end
      if (s_out && !ps) k++;
      {ps, pc, pl, pr, pd} = {s_out, ch_clk, lco, rco, ser};
    end
    if (k < 3) give_up();
  endtask : count_chan
  // ----------------------------------------------------------------
  // Clock, reset and test sequence.
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    {rstn_in, rd, wr, search, cl, bp_hold} = 6'h00;
    {addr, wdata, fails, compares} = '0;
    {tx_run, bus_type_strap} = 2'b11;
    idle(2);
    rstn_in <= 1'b1;
    idle(20);
    chk(bm, 1'b1);
    bus(0, REG_CTRL, 0);  chk(d, 32'h50);
    bus(0, REG_MASK1, 0); chk(d, 32'h7);
    bus(0, REG_BLOCK, 0); chk(d, 32'h0);
    bus(0, 4'hF, 0);      chk(d, 32'h0);
    bus(1, REG_CTRL, 0);  bus(0, REG_CTRL, 0);   chk(d, 32'h50);
    bus(1, REG_BLOCK, 32'h80000001); bus(0, REG_BLOCK, 0); chk(d, 32'h80000001);
    count_chan();         chk(c, 64);
    chk(b, 4);
    chk(l, 1);
    chk(r, 512);
    chk(e, 0);
    chk(s > 0, 1);
    chk(i2, 1'b1);
    bus(1, REG_MASK2, 0); bus(1, REG_STAT2, 7);  idle(4);
    chk(i2, 1'b0);
    chk(irq, 1'b0);
    search <= 1'b1;       idle(12);
    chk(loss, 1'b1);
    chk({i1, irq}, 2'b11);
    chk({a1, a2}, 2'b00);
    search <= 1'b0;       idle(12);
    chk(loss, 1'b0);
    bus(1, REG_STAT1, 7); idle(4);
    chk(i1, 1'b0);
    bus(1, REG_CTRL, 32'h58);
    tx_run <= 1'b0;       idle(1100);
    chk(loss, 1'b1);
    bus(0, REG_STAT1, 0); chk(d, 32'h4);
    tx_run <= 1'b1;       idle(300);
    chk(loss, 1'b0);
    cl <= 1'b1;           idle(10);
    chk(rco, 1'b0);
    idle(8);
    chk(rco, 1'b0);
    bus(0, REG_STAT1, 0); chk(d, 32'h6);
    cl <= 1'b0;
    bp_hold <= 1'b1;      idle(80);
    chk(drv, 1'b0);
    bp_hold <= 1'b0;      idle(10);
    bus_type_strap <= 1'b0;          idle(8);
    chk(bm, 1'b0);
    results();
  end
endmodule : test_e1r_rx_pins
